//--- include/phase_rebuild_pkg.sv
package phase_rebuild_pkg;
	// Register byte offsets
	localparam logic [7:0] off_ctrl = 8'h00;
	localparam logic [7:0] off_bias = 8'h04;
	localparam logic [7:0] off_adj = 8'h08;
	localparam logic [7:0] off_range = 8'h0C;
	localparam logic [7:0] off_status = 8'h10;
	localparam logic [7:0] off_int_stat = 8'h14;
	localparam logic [7:0] off_int_mask = 8'h18;
	localparam logic [7:0] off_offset = 8'h1C;
	// Control field positions
	localparam int ctrl_enable_bit = 0;
	localparam int ctrl_hold_bit = 1;
	localparam int ctrl_eight_khz_bit = 2;
	// Reset values
	localparam logic [2:0] ctrl_reset = 3'h1;
	// Acceptance range in 0.08 ppm units: 9.2 ppm is 115
	localparam logic [9:0] range_reset = 10'h073;
	localparam logic [9:0] range_max = 10'h3E8;
	// Bias step 0.101 ns, limit 1.4 ns: 13 steps
	localparam int bias_step_ps = 101;
	localparam int bias_limit_ps = 1400;
	localparam logic signed [4:0] bias_limit = 5'(bias_limit_ps / bias_step_ps);
	// Adjust step 6 ps, span 200 ns
	localparam int adj_step_ps = 6;
	localparam int adj_span_ps = 200000;
	// Kept as int: the step count can exceed what a signed 16-bit value holds
	localparam int adj_limit = adj_span_ps / adj_step_ps;
	// Transient bound 5 ns
	localparam int transient_ps = 5000;
	// Measure state length in cycles
	localparam logic [3:0] measure_cycles = 4'h8;
	// Interrupt bits
	localparam int irq_rebuild = 0;
	localparam int irq_switch = 1;
	localparam int irq_reject = 2;
	localparam int irq_width = 3;
	// Loop states
	typedef enum logic [1:0] {st_locked, st_holdover, st_measure, st_load} loop_state_t;
endpackage : phase_rebuild_pkg

//--- rtl/phase_build_out_control.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
// Function
// - Lost reference: switch next priority, fire rebuild
// - Rebuild acts on main path only
// - Rebuild: holdover, measure, load offset
// - Output transient after rebuild within 5 ns
// - Enable bit, enabled after reset
// - Hold bit freezes offset, events switch without rebuild
// - Disabled while locked: return to zero error
// - Enabling while locked fires rebuild
// - Signed bias 0.101 ns steps, 1.4 ns limit
// - Rebuild off: align to zero plus adjust
// - Adjust 6 ps steps, 200 ns, 16 bits
// - Adjust shifts feedback phase
// - Adjust used only while rebuild disabled
// - Reject reference outside hold-in range
// - Reject reference on eye closure
// - Range 9.2 ppm default, 0-80 ppm
module phase_build_out_control #(
	parameter int num_refs = 4,
	parameter int phase_width = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reference monitor pins, asynchronous
	input wire logic [num_refs-1:0] ref_lost,
	input wire logic [num_refs-1:0] ref_eye_closed,
	// Measured frequency offset per reference, 0.08 ppm units, same clock
	input wire logic [num_refs*10-1:0] ref_freq_offset,
	// Measured input-to-output phase, ps, same clock
	input wire logic signed [phase_width-1:0] measured_phase,
	input wire logic loop_locked,
	// Loop side outputs
	output logic [$clog2(num_refs)-1:0] selected_ref,
	output logic holdover,
	output logic signed [phase_width+3:0] feedback_phase_shift,
	output logic rebuild_event,
	output logic eight_khz_lock_mode,
	output logic irq
);
	localparam int sel_w = $clog2(num_refs);

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Sign-extend bias steps into ps
	function automatic logic signed [phase_width+3:0] bias_ps(input logic signed [4:0] b);
		bias_ps = (phase_width+4)'(b * phase_rebuild_pkg::bias_step_ps);
	endfunction : bias_ps

	// Clamp adjust value into the documented span
	// Compared as int so a limit beyond the 16-bit range cannot wrap negative
	function automatic logic signed [15:0] clamp_adj(input logic signed [15:0] v);
		if (int'(v) > phase_rebuild_pkg::adj_limit) begin
			clamp_adj = 16'(phase_rebuild_pkg::adj_limit);
		end else if (int'(v) < -phase_rebuild_pkg::adj_limit) begin
			clamp_adj = 16'(-phase_rebuild_pkg::adj_limit);
		end else begin
			clamp_adj = v;
		end
	endfunction : clamp_adj

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [num_refs-1:0] lost_s1, lost_s2; // Loss sync stages
	logic [num_refs-1:0] eye_s1, eye_s2; // Eye sync stages

	// Two flops on each asynchronous pin
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			lost_s1 <= '0;
			lost_s2 <= '0;
			eye_s1 <= '0;
			eye_s2 <= '0;
		end else begin
			lost_s1 <= ref_lost;
			lost_s2 <= lost_s1;
			eye_s1 <= ref_eye_closed;
			eye_s2 <= eye_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	localparam int irq_w_c = phase_rebuild_pkg::irq_width; // Interrupt bit count

	logic [2:0] ctrl, next_ctrl; // Enable, hold, 8 kHz mode
	logic signed [4:0] bias, next_bias; // Rebuild bias steps
	logic signed [15:0] adj, next_adj; // Output phase adjust
	logic [9:0] range, next_range; // Hold-in range
	logic [irq_w_c-1:0] int_stat, next_int_stat; // Sticky events
	logic [irq_w_c-1:0] int_mask, next_int_mask; // Event mask

	logic enable; // Rebuild enabled
	logic hold; // Rebuild frozen
	logic [irq_w_c-1:0] events; // Raw event pulses
	logic wr; // Write strobe
	logic signed [phase_width+3:0] offset; // Rebuild offset
	logic [num_refs-1:0] rejected; // Rejected references
	logic [num_refs-1:0] rejected_q; // Rejections seen last cycle

	assign enable = ctrl[phase_rebuild_pkg::ctrl_enable_bit];
	assign hold = ctrl[phase_rebuild_pkg::ctrl_hold_bit];
	assign eight_khz_lock_mode = ctrl[phase_rebuild_pkg::ctrl_eight_khz_bit];
	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;

	// Register next values
	always_comb begin
		next_ctrl = ctrl;
		next_bias = bias;
		next_adj = adj;
		next_range = range;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		if (wr) begin
			unique case (paddr)
				phase_rebuild_pkg::off_ctrl: begin
					next_ctrl = pwdata[2:0];
				end
				phase_rebuild_pkg::off_bias: begin
					// Clamp bias into limit
					// Whole word compared, so large values saturate, not wrap
					if ($signed(pwdata) > phase_rebuild_pkg::bias_limit) begin
						next_bias = phase_rebuild_pkg::bias_limit;
					end else if ($signed(pwdata) < -phase_rebuild_pkg::bias_limit) begin
						next_bias = -phase_rebuild_pkg::bias_limit;
					end else begin
						next_bias = pwdata[4:0];
					end
				end
				phase_rebuild_pkg::off_adj: begin
					next_adj = clamp_adj(pwdata[15:0]);
				end
				phase_rebuild_pkg::off_range: begin
					// Range capped at 80 ppm
					next_range = (pwdata[9:0] > phase_rebuild_pkg::range_max) ?
						phase_rebuild_pkg::range_max : pwdata[9:0];
				end
				phase_rebuild_pkg::off_int_stat: begin
					next_int_stat = int_stat & ~pwdata[irq_w_c-1:0];
				end
				phase_rebuild_pkg::off_int_mask: begin
					next_int_mask = pwdata[irq_w_c-1:0];
				end
				default: begin
				end
			endcase
		end
		// Set wins over clear
		next_int_stat = next_int_stat | events;
	end

	// Register storage
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl <= phase_rebuild_pkg::ctrl_reset;
			bias <= '0;
			adj <= '0;
			range <= phase_rebuild_pkg::range_reset;
			int_stat <= '0;
			int_mask <= '0;
		end else begin
			ctrl <= next_ctrl;
			bias <= next_bias;
			adj <= next_adj;
			range <= next_range;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
		end
	end

	assign irq = |(int_stat & int_mask);

	////////////////////////////////////////////////////////////////////////////
	// Reference rejection and selection

	// Reject on loss, eye closure or range overrun
	always_comb begin
		for (int i = 0; i < num_refs; i++) begin
			rejected[i] = lost_s2[i] || eye_s2[i]
				|| (ref_freq_offset[i*10 +: 10] > range);
		end
	end

	logic [sel_w-1:0] next_sel; // Next reference
	logic sel_valid; // Any reference usable
	logic switch_now; // Selected one just failed

	// Lowest index is highest priority
	always_comb begin
		next_sel = selected_ref;
		sel_valid = 1'b0;
		for (int i = num_refs - 1; i >= 0; i--) begin
			if (!rejected[i]) begin
				next_sel = sel_w'(i);
				sel_valid = 1'b1;
			end
		end
	end

	assign switch_now = rejected[selected_ref] && sel_valid;

	////////////////////////////////////////////////////////////////////////////
	// Rebuild state machine, main path only

	phase_rebuild_pkg::loop_state_t state, next_state; // Rebuild state
	logic [3:0] count, next_count; // Measure state timer
	logic signed [phase_width+3:0] next_offset; // Next offset
	logic [sel_w-1:0] next_selected; // Next selected
	logic enable_q, next_enable_q; // Enable delayed
	logic [num_refs-1:0] next_rejected_q; // Next rejection history
	logic trigger; // Rebuild trigger

	// Rising enable while locked triggers too
	assign trigger = enable && !hold && (switch_now
		|| (!enable_q && loop_locked));

	// Sequencer next values
	always_comb begin
		next_state = state;
		next_count = count;
		next_offset = offset;
		next_selected = switch_now ? next_sel : selected_ref;
		next_enable_q = enable;
		next_rejected_q = rejected;
		rebuild_event = 1'b0;
		unique case (state)
			phase_rebuild_pkg::st_locked: begin
				if (trigger) begin
					rebuild_event = 1'b1;
					next_state = phase_rebuild_pkg::st_holdover;
					next_count = '0;
				end
			end
			phase_rebuild_pkg::st_holdover: begin
				next_state = phase_rebuild_pkg::st_measure;
			end
			phase_rebuild_pkg::st_measure: begin
				// Let phase settle before sampling
				next_count = count + 4'h1;
				if (count == phase_rebuild_pkg::measure_cycles - 4'h1) begin
					next_state = phase_rebuild_pkg::st_load;
				end
			end
			phase_rebuild_pkg::st_load: begin
				// Cancel measured phase plus bias
				next_offset = (phase_width+4)'(measured_phase) + bias_ps(bias);
				next_state = phase_rebuild_pkg::st_locked;
			end
		endcase
		// Disabled: offset returns to zero via loop
		if (!enable) begin
			next_offset = '0;
			next_state = phase_rebuild_pkg::st_locked;
		end
	end

	// Sequencer storage, offset held until next event
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= phase_rebuild_pkg::st_locked;
			count <= '0;
			offset <= '0;
			selected_ref <= '0;
			// Matches the enable reset value: no false rising edge after reset
			enable_q <= phase_rebuild_pkg::ctrl_reset[phase_rebuild_pkg::ctrl_enable_bit];
			rejected_q <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
			offset <= next_offset;
			selected_ref <= next_selected;
			enable_q <= next_enable_q;
			rejected_q <= next_rejected_q;
		end
	end

	assign holdover = (state != phase_rebuild_pkg::st_locked);

	// Feedback shift: offset when on, adjust when off
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			feedback_phase_shift <= '0;
		end else if (enable) begin
			feedback_phase_shift <= offset;
		end else begin
			feedback_phase_shift <= (phase_width+4)'(adj * phase_rebuild_pkg::adj_step_ps);
		end
	end

	assign events = {irq_w_c{1'b0}} | ({2'b00, rebuild_event} << phase_rebuild_pkg::irq_rebuild)
		| ({2'b00, switch_now} << phase_rebuild_pkg::irq_switch)
		| ({2'b00, |(rejected & ~rejected_q)} << phase_rebuild_pkg::irq_reject);
	// Reject event marks a new rejection only, so a clear can stick

	////////////////////////////////////////////////////////////////////////////
	// Read mux

	logic [31:0] next_prdata; // Read value

	// Read value of the addressed register
	always_comb begin
		next_prdata = '0;
		unique case (paddr)
			phase_rebuild_pkg::off_ctrl: next_prdata = 32'(ctrl);
			phase_rebuild_pkg::off_bias: next_prdata = 32'(signed'(bias));
			phase_rebuild_pkg::off_adj: next_prdata = 32'(adj);
			phase_rebuild_pkg::off_range: next_prdata = 32'(range);
			phase_rebuild_pkg::off_status: next_prdata = 32'({rejected, selected_ref, state});
			phase_rebuild_pkg::off_int_stat: next_prdata = 32'(int_stat);
			phase_rebuild_pkg::off_int_mask: next_prdata = 32'(int_mask);
			phase_rebuild_pkg::off_offset: next_prdata = 32'(offset);
			default: next_prdata = '0;
		endcase
	end

	// Capture read data in the setup cycle; it stands through the access
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			// Read setup seen: load the addressed value
			prdata <= next_prdata;
		end
	end

	assign pslverr = 1'b0;
endmodule : phase_build_out_control

//--- sim/phase_rebuild_chk.sv
`timescale 1ns/1ps
// Port-level watch of the phase rebuild block
module phase_rebuild_chk #(
	parameter int num_refs = 4,
	parameter int phase_width = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [num_refs-1:0] ref_lost,
	input wire logic [num_refs-1:0] ref_eye_closed,
	input wire logic [num_refs*10-1:0] ref_freq_offset,
	input wire logic signed [phase_width-1:0] measured_phase,
	input wire logic loop_locked,
	input wire logic [$clog2(num_refs)-1:0] selected_ref,
	input wire logic holdover,
	input wire logic signed [phase_width+3:0] feedback_phase_shift,
	input wire logic rebuild_event,
	input wire logic eight_khz_lock_mode,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	logic wr; // Completed write
	logic [4:0] quiet; // Cycles since rebuild or write
	logic [4:0] next_quiet;
	logic [1:0] ctrl_now; // Enable and hold bits as written
	logic [1:0] next_ctrl_now;
	logic lock_req; // Lock mode bit being written
	assign wr = psel && penable && pwrite;
	assign lock_req = pwdata[phase_rebuild_pkg::ctrl_eight_khz_bit];
	// Next values of the helper state
	always_comb begin
		next_quiet = (quiet == 5'h1F) ? quiet : quiet + 5'h01;
		next_ctrl_now = ctrl_now;
		if (wr && paddr == 8'h00) begin
			next_ctrl_now = pwdata[1:0];
		end
		if (rebuild_event || wr || !nrst) begin
			next_quiet = 5'h00;
		end
		if (!nrst) begin
			next_ctrl_now = 2'h1;
		end
	end
	// Register the helper state
	always_ff @(posedge sys_clk) begin
		quiet <= next_quiet;
		ctrl_now <= next_ctrl_now;
	end
	sequence rebuild_start_s;
		rebuild_event ##1 holdover;
	endsequence
	event_pulse_a: assert property (rebuild_event |=> !rebuild_event)
		else $error("rebuild pulse too long");
	rebuild_hold_a: assert property (rebuild_event |-> rebuild_start_s)
		else $error("no holdover after rebuild");
	holdover_end_a: assert property ($rose(holdover) |-> ##[1:12] !holdover)
		else $error("holdover too long");
	loss_switch_a: assert property (ref_lost[selected_ref] && !(&ref_lost) |->
		##[1:8] !ref_lost[selected_ref])
		else $error("lost reference kept");
	offset_quiet_a: assert property ($changed(feedback_phase_shift) |-> quiet < 5'h10)
		else $error("offset moved without cause");
	hold_ignores_a: assert property (ctrl_now == 2'h3 |-> !rebuild_event)
		else $error("rebuild while held");
	lock_mode_a: assert property (wr && paddr == phase_rebuild_pkg::off_ctrl |=>
		eight_khz_lock_mode == $past(lock_req))
		else $error("lock mode not applied");
	bias_clamp_a: assert property (psel && penable && !pwrite &&
		paddr == phase_rebuild_pkg::off_bias |->
		$signed(prdata[4:0]) >= -phase_rebuild_pkg::bias_limit &&
		$signed(prdata[4:0]) <= phase_rebuild_pkg::bias_limit)
		else $error("bias out of range");
	range_clamp_a: assert property (psel && penable && !pwrite &&
		paddr == phase_rebuild_pkg::off_range |-> prdata[9:0] <= phase_rebuild_pkg::range_max)
		else $error("range out of limit");
endmodule : phase_rebuild_chk
bind phase_build_out_control phase_rebuild_chk #(.num_refs(num_refs), .phase_width(phase_width))
	u_chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ref_lost(ref_lost), .ref_eye_closed(ref_eye_closed), .ref_freq_offset(ref_freq_offset),
	.measured_phase(measured_phase), .loop_locked(loop_locked), .selected_ref(selected_ref),
	.holdover(holdover), .feedback_phase_shift(feedback_phase_shift),
	.rebuild_event(rebuild_event), .eight_khz_lock_mode(eight_khz_lock_mode), .irq(irq));

//--- sim/ref_source_model.sv
`timescale 1ns/1ps
// Four reference sources and the loop's phase detector
module ref_source_model (
	input wire logic sys_clk,
	input wire logic [1:0] selected_ref,
	input wire logic [3:0] drop,
	input wire logic [3:0] eye_bad,
	input wire logic [9:0] drift,
	output logic [3:0] ref_lost,
	output logic [3:0] ref_eye_closed,
	output logic [39:0] ref_freq_offset,
	output logic signed [15:0] measured_phase,
	output logic loop_locked
);
	// Source levels; reference n sits n ns from the output
	always_ff @(posedge sys_clk) begin
		ref_lost <= drop;
		ref_eye_closed <= eye_bad;
		ref_freq_offset <= {10'h000, drift, 20'h0_0000};
		measured_phase <= 16'(selected_ref) * 16'h03E8;
		loop_locked <= 1'b1;
	end
endmodule : ref_source_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} row_t;
	logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, holdover, rebuild_event, irq;
	logic eight_khz_lock_mode, loop_locked;
	logic [7:0] paddr, events, ev0;
	logic [31:0] pwdata, prdata, q, errors, comparisons;
	logic [3:0] ref_lost, ref_eye_closed, drop, eye_bad;
	logic [39:0] ref_freq_offset;
	logic [9:0] drift;
	logic signed [15:0] measured_phase;
	logic [1:0] selected_ref;
	logic signed [19:0] feedback_phase_shift, f1;
	row_t rows [9];
	phase_build_out_control u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_lost(ref_lost), .ref_eye_closed(ref_eye_closed),
		.ref_freq_offset(ref_freq_offset), .measured_phase(measured_phase),
		.loop_locked(loop_locked), .selected_ref(selected_ref), .holdover(holdover),
		.feedback_phase_shift(feedback_phase_shift), .rebuild_event(rebuild_event),
		.eight_khz_lock_mode(eight_khz_lock_mode), .irq(irq));
	ref_source_model u_src (.sys_clk(sys_clk), .selected_ref(selected_ref), .drop(drop),
		.eye_bad(eye_bad), .drift(drift), .ref_lost(ref_lost), .ref_eye_closed(ref_eye_closed),
		.ref_freq_offset(ref_freq_offset), .measured_phase(measured_phase),
		.loop_locked(loop_locked));
	////////////////////////////////////////////////////////////////
	// Clock and rebuild pulse counter
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (rebuild_event === 1'b1) events <= events + 8'h01;
	end
	// Compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One APB transfer, idle cycle before it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Ends once pready is high; the watchdog ends it if pready never rises
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic settle();
		repeat (30) @(posedge sys_clk);
	endtask : settle
	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	// Watchdog
	initial begin
		#100000;
		errors = errors + 1;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, drop, eye_bad, drift} = '0;
		{events, errors, comparisons} = '0;
		rows = '{'{8'h04, 32'h0000_0005, 32'h0000_001F, 32'h0000_0005},
			'{8'h04, 32'h0000_0014, 32'h0000_001F, 32'h0000_000D},
			'{8'h04, 32'hFFFF_FFEC, 32'h0000_001F, 32'h0000_0013},
			'{8'h04, 32'h0000_0000, 32'h0000_001F, 32'h0000_0000},
			'{8'h08, 32'h0000_8000, 32'h0000_FFFF, 32'h0000_8000},
			'{8'h08, 32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000},
			'{8'h0C, 32'h0000_03FF, 32'h0000_03FF, 32'h0000_03E8},
			'{8'h0C, 32'h0000_0073, 32'h0000_03FF, 32'h0000_0073},
			'{8'h20, 32'h0000_00FF, 32'hFFFF_FFFF, 32'h0000_0000}};
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		apb(0, 8'h00, 32'h0);
		check(q & 32'h0000_0007, 32'h0000_0001);
		apb(0, 8'h0C, 32'h0);
		check(q & 32'h0000_03FF, 32'h0000_0073);
		check({24'h0, events}, 32'h0);
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 32'h0);
			check(q & rows[i].m, rows[i].e);
		end
		// Loss of reference 0: switch, rebuild, interrupt
		apb(1, 8'h18, 32'h0000_0007);
		drop <= 4'h1;
		settle();
		check({30'h0, selected_ref}, 32'h1);
		check({24'h0, events}, 32'h1);
		f1 = feedback_phase_shift;
		check({12'h0, f1[19] ? -f1 : f1}, 32'h0000_03E8);
		check({31'h0, irq}, 32'h1);
		apb(0, 8'h1C, 32'h0);
		check(q, 32'h0000_03E8);
		apb(0, 8'h10, 32'h0);
		check(q & 32'h0000_00FF, 32'h0000_0014);
		apb(0, 8'h14, 32'h0);
		check(q & 32'h0000_0007, 32'h0000_0007);
		apb(1, 8'h14, 32'h0000_0007);
		apb(0, 8'h14, 32'h0);
		check(q & 32'h0000_0007, 32'h0);
		// Hold: switch without rebuild, offset kept
		apb(1, 8'h00, 32'h0000_0003);
		drop <= 4'h3;
		settle();
		check({30'h0, selected_ref}, 32'h2);
		check({24'h0, events}, 32'h1);
		check({12'h0, feedback_phase_shift}, {12'h0, f1});
		// Out of range on reference 2, interrupt masked
		apb(1, 8'h00, 32'h0000_0001);
		apb(1, 8'h18, 32'h0);
		apb(1, 8'h0C, 32'h0000_000A);
		drift <= 10'h064;
		settle();
		check({30'h0, selected_ref}, 32'h3);
		check({31'h0, irq}, 32'h0);
		apb(0, 8'h14, 32'h0);
		check(q & 32'h0000_0004, 32'h0000_0004);
		// Rebuild off: offset cleared, adjust drives feedback in 6 ps steps
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h08, 32'h0000_0100);
		settle();
		check({12'h0, feedback_phase_shift}, 32'h0000_0600);
		apb(0, 8'h1C, 32'h0);
		check(q, 32'h0);
		apb(1, 8'h08, 32'h0000_0200);
		settle();
		check({12'h0, feedback_phase_shift}, 32'h0000_0C00);
		apb(1, 8'h08, 32'h0000_FFFF);
		settle();
		check({12'h0, feedback_phase_shift}, 32'h000F_FFFA);
		// Enabling while locked fires rebuild with bias; adjust then ignored
		apb(1, 8'h04, 32'h0000_0005);
		ev0 = events + 8'h01;
		apb(1, 8'h00, 32'h0000_0005);
		settle();
		check({24'h0, events}, {24'h0, ev0});
		check({31'h0, eight_khz_lock_mode}, 32'h1);
		f1 = feedback_phase_shift;
		check({12'h0, f1}, 32'h0000_0DB1);
		apb(1, 8'h08, 32'h0000_0300);
		settle();
		check({12'h0, feedback_phase_shift}, {12'h0, f1});
		// Eye closure on reference 3 rejected, 8 kHz mode kept for jitter
		check({31'h0, eight_khz_lock_mode}, 32'h1);
		apb(1, 8'h14, 32'h0000_0007);
		apb(1, 8'h18, 32'h0000_0004);
		eye_bad <= 4'h8;
		settle();
		check({31'h0, irq}, 32'h1);
		apb(0, 8'h14, 32'h0);
		check(q & 32'h0000_0004, 32'h0000_0004);
		test_done();
	end
endmodule : tb
